/* File: verilog/pio_top.sv */
// Parallel I/O tail: data readback, pin levels, edge interrupts, open drain, AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pio_top
  import pio_pkg::*;
#(
  parameter int N = 32
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output wire logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output wire logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output wire logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [N-1:0]          line_owner,
  input  wire logic [N-1:0]          output_enable_state,
  input  wire logic [N-1:0]          pin_in,
  output      pio_pkg::pio_pad_t     pad,
  output wire logic                  irq
);
  import pio_pkg::*;

  logic [N-1:0] odata_reg;
  logic [N-1:0] irq_mask_reg;
  logic [N-1:0] edge_flags_reg;
  logic [N-1:0] od_state_reg;
  logic [N-1:0] pin_sync1_reg;
  logic [N-1:0] pin_sync2_reg;
  logic [N-1:0] pin_prev_reg;
  logic         aw_held_reg;
  logic [7:0]   awaddr_reg;
  logic         w_held_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   wstrb_reg;

  // Write: address and data latched independently, committed when both held
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held_reg && w_held_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_reg <= 1'b0;
      if (w_hs)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_reg <= 1'b0;
    end
  end

  // Byte strobes mask the set/clear word so untouched lanes have no effect
  logic [31:0] wmask;
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[8*b +: 8] = wdata_reg[8*b +: 8] & {8{wstrb_reg[b]}};
  end
  wire [N-1:0] wbits   = wmask[N-1:0];
  wire         wr_ok   = (awaddr_reg[1:0] == 2'h0);
  wire         wr_oset = wr_fire && wr_ok && (awaddr_reg == OFF_OUT_SET);
  wire         wr_oclr = wr_fire && wr_ok && (awaddr_reg == OFF_OUT_CLR);
  wire         wr_ieset = wr_fire && (awaddr_reg == OFF_IRQ_EN_SET);
  wire         wr_ieclr = wr_fire && (awaddr_reg == OFF_IRQ_EN_CLR);
  wire         wr_odset = wr_fire && (awaddr_reg == OFF_OD_SET);
  wire         wr_odclr = wr_fire && (awaddr_reg == OFF_OD_CLR);
  wire         wr_hit  = wr_oset || wr_oclr || wr_ieset || wr_ieclr || wr_odset || wr_odclr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Clear applied after set, so a word touching both leaves the line low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      odata_reg <= RST_ODATA[N-1:0];
    else
      odata_reg <= (odata_reg | (wr_oset ? wbits : '0))
                   & ~(wr_oclr ? wbits : '0);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_reg <= RST_IRQ_MASK[N-1:0];
    else
      irq_mask_reg <= (irq_mask_reg | (wr_ieset ? wbits : '0))
                      & ~(wr_ieclr ? wbits : '0);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      od_state_reg <= RST_OD_STATE[N-1:0];
    else
      od_state_reg <= (od_state_reg | (wr_odset ? wbits : '0))
                      & ~(wr_odclr ? wbits : '0);
  end

  // Pins are asynchronous; the first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    pin_sync1_reg <= pin_in;
    pin_sync2_reg <= pin_sync1_reg;
  end

  // Previous level loaded from the synchroniser so reset invents no edge
  logic prev_valid_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_valid_reg <= 1'b0;
    else
      prev_valid_reg <= 1'b1;
    pin_prev_reg <= pin_sync2_reg;
  end
  wire [N-1:0] edge_seen = prev_valid_reg ? (pin_sync2_reg ^ pin_prev_reg) : '0;

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire rd_flags = ar_hs && (s_axi_araddr == OFF_EDGE_FLAGS);

  // Set wins over the read-clear so an edge in the read cycle is kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      edge_flags_reg <= RST_EDGE_FLAGS[N-1:0];
    else
      edge_flags_reg <= (rd_flags ? '0 : edge_flags_reg) | edge_seen;
  end

  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      OFF_ODATA:      rd_word[N-1:0] = odata_reg;
      OFF_PIN_LEVEL:  rd_word[N-1:0] = pin_sync2_reg;
      OFF_IRQ_MASK:   rd_word[N-1:0] = irq_mask_reg;
      OFF_EDGE_FLAGS: rd_word[N-1:0] = edge_flags_reg;
      OFF_OD_STATE:   rd_word[N-1:0] = od_state_reg;
      OFF_OUT_SET, OFF_OUT_CLR, OFF_IRQ_EN_SET, OFF_IRQ_EN_CLR,
      OFF_OD_SET, OFF_OD_CLR: rd_word = 32'h0000_0000;
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Pad drive per line; registered so the pad never glitches on decode
  logic [N-1:0] pad_out_reg;
  logic [N-1:0] pad_oe_reg;
  wire  [N-1:0] pad_out_next;
  wire  [N-1:0] pad_oe_next;
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_line
      wire drive = line_owner[g] && output_enable_state[g];
      assign pad_out_next[g] = od_state_reg[g] ? 1'b0 : odata_reg[g];
      assign pad_oe_next[g]  = drive && !(od_state_reg[g] && odata_reg[g]);
    end
  endgenerate

  // Reset releases every pad so nothing fights the board while it boots
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_out_reg <= '0;
      pad_oe_reg  <= '0;
    end
    else
    begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg  <= pad_oe_next;
    end
  end

  // Lines above N are never driven
  always_comb
  begin
    pad            = '0;
    pad.out[N-1:0] = pad_out_reg;
    pad.oe[N-1:0]  = pad_oe_reg;
  end

  assign irq = |(edge_flags_reg & irq_mask_reg);

  // Checks
  sequence s_edge_on_pin(int i);
    prev_valid_reg && (pin_sync2_reg[i] != pin_prev_reg[i]);
  endsequence

  a_edge_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    s_edge_on_pin(0) |=> edge_flags_reg[0])
    else $error("edge on line 0 did not set its flag");
  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_flags && edge_seen == '0) |=> (edge_flags_reg == '0))
    else $error("status read did not clear flags");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (edge_flags_reg[1] && !rd_flags) |=> edge_flags_reg[1])
    else $error("flag dropped without a read");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == (|(edge_flags_reg & irq_mask_reg)))
    else $error("interrupt output disagrees with flags and mask");
  a_mask_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ieset && !wr_ieclr && wbits[16]) |=> irq_mask_reg[16])
    else $error("enable-set write did not enable line 16");
  a_mask_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ieclr && wbits[24]) |=> !irq_mask_reg[24])
    else $error("enable-clear write did not disable line 24");
  a_odata_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_oset && wbits[2]) |=> odata_reg[2])
    else $error("output set write did not set line 2");
  a_odata_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_oclr && wbits[2]) |=> !odata_reg[2])
    else $error("output clear write did not clear line 2");
  a_od_state: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_odset && !wr_odclr && wbits[12]) |=> od_state_reg[12])
    else $error("open-drain set write did not take");
  a_od_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_odclr && wbits[12]) |=> !od_state_reg[12])
    else $error("open-drain clear write did not take");
  a_no_drive_unowned: assert property (@(posedge aclk) disable iff (!aresetn)
    !(line_owner[0] && output_enable_state[0]) |=> !pad.oe[0])
    else $error("pad driven on a line not owned or not enabled");
  a_od_never_high: assert property (@(posedge aclk) disable iff (!aresetn)
    od_state_reg[12] |=> !(pad.oe[12] && pad.out[12]))
    else $error("open-drain line driven high");
  a_pin_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && s_axi_araddr == OFF_PIN_LEVEL) |=> (s_axi_rdata[N-1:0] == $past(pin_sync2_reg)))
    else $error("pin level readback mismatched");
  a_odata_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && s_axi_araddr == OFF_ODATA) |=> (s_axi_rdata[N-1:0] == $past(odata_reg)))
    else $error("output data readback mismatched");
  a_mask_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && s_axi_araddr == OFF_IRQ_MASK) |=> (s_axi_rdata[N-1:0] == $past(irq_mask_reg)))
    else $error("mask readback mismatched");
  a_od_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && s_axi_araddr == OFF_OD_STATE) |=> (s_axi_rdata[N-1:0] == $past(od_state_reg)))
    else $error("open-drain readback mismatched");
  a_oe_from_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    (line_owner[1] && output_enable_state[1] && !od_state_reg[1]) |=> pad.oe[1])
    else $error("owned enabled push-pull line not driven");

  // Bus answers stand until the master takes them
  // Both halves of a write are held: this is the commit cycle
  sequence s_write_commit;
    aw_held_reg && w_held_reg;
  endsequence

  // Read address accepted in this cycle
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_commit |=> s_axi_bvalid)
    else $error("write commit gave no response");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_taken |=> s_axi_rvalid)
    else $error("read address taken without a read response");
  a_bresp_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before it was taken");
  a_rdata_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data changed before it was taken");
  a_no_accept_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write channel ready while a response is pending");

  // Flags rise only on an edge, and reset leaves nothing behind
  a_flag_needs_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (!edge_flags_reg[0] && !edge_seen[0]) |=> !edge_flags_reg[0])
    else $error("flag on line 0 set with no edge");
  a_reset_clears: assert property (@(posedge aclk)
    !aresetn |=> (edge_flags_reg == '0 && irq_mask_reg == '0 && odata_reg == '0
                  && od_state_reg == '0 && !irq && pad.oe == '0))
    else $error("reset left state behind");
  a_pin_two_flops: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |-> (pin_sync2_reg == $past(pin_in, 2)))
    else $error("pin level not two flops behind the pin");

  // Pad follows the programmed value on push-pull lines and floats a one on open drain
  a_od_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (od_state_reg[12] && odata_reg[12]) |=> !pad.oe[12])
    else $error("open-drain line holding a one still driven");
  a_pad_value: assert property (@(posedge aclk) disable iff (!aresetn)
    !od_state_reg[1] |=> (pad.out[1] == $past(odata_reg[1])))
    else $error("push-pull pad value differs from programmed value");
endmodule : pio_top

/* File: verilog/pio_pkg.sv */
// Package: register map, reset values and carrier types for the parallel I/O tail block
package pio_pkg;
  localparam int          PIO_LINES      = 32;
  localparam logic [7:0]  OFF_OUT_SET    = 8'h30;
  localparam logic [7:0]  OFF_OUT_CLR    = 8'h34;
  localparam logic [7:0]  OFF_ODATA      = 8'h38;
  localparam logic [7:0]  OFF_PIN_LEVEL  = 8'h3C;
  localparam logic [7:0]  OFF_IRQ_EN_SET = 8'h40;
  localparam logic [7:0]  OFF_IRQ_EN_CLR = 8'h44;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h48;
  localparam logic [7:0]  OFF_EDGE_FLAGS = 8'h4C;
  localparam logic [7:0]  OFF_OD_SET     = 8'h50;
  localparam logic [7:0]  OFF_OD_CLR     = 8'h54;
  localparam logic [7:0]  OFF_OD_STATE   = 8'h58;
  localparam logic [31:0] RST_ODATA      = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK   = 32'h0000_0000;
  localparam logic [31:0] RST_EDGE_FLAGS = 32'h0000_0000;
  localparam logic [31:0] RST_OD_STATE   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Per-line pin drive towards the pad
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } pio_pad_t;
endpackage : pio_pkg

/* File: verification/pio_pin_model.sv */
// Pin model: pull-up pads shared between the block and an outside driver
`timescale 1ns/1ps
module pio_pin_model
  import pio_pkg::*;
(
  input  wire pio_pkg::pio_pad_t pad,
  input  wire logic [31:0]       ext_en,
  input  wire logic [31:0]       ext_val,
  output logic [31:0]            pin
);
  // Wired-AND with pull-up: a released pad floats high and any low driver wins
  assign pin = ~(pad.oe & ~pad.out) & ~(ext_en & ~ext_val);
endmodule : pio_pin_model

/* File: verification/tb_parallel_io_status_irq_opendrain.sv */
// Self-checking bench for the parallel I/O readback, edge interrupt and open-drain block
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_parallel_io_status_irq_opendrain;
  import pio_pkg::*;
  typedef struct {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  rsp;
    logic [31:0] rd;
  } pio_row_t;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic [31:0] line_owner = 32'h0;
  logic [31:0] oe_st = 32'h0;
  logic [31:0] ext_en = 32'h0;
  logic [31:0] ext_val = 32'h0;
  logic [31:0] pin_in;
  logic [31:0] rdata;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic        irq;
  pio_pad_t    pad;
  pio_row_t    rows [20];
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #50 aclk = ~aclk;

  pio_top #(.N(PIO_LINES)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_owner(line_owner), .output_enable_state(oe_st), .pin_in(pin_in), .pad(pad),
    .irq(irq));

  pio_pin_model pins_u (.pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin(pin_in));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // Handshakes are judged on values settled before the edge; a hang ends by the timeout
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_go;
    logic w_go;
    logic b_go;
    b_go    = 1'h0;
    r       = 2'h0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!b_go)
    begin
      @(negedge aclk);
      aw_go = awvalid && (awready === 1'h1);
      w_go  = wvalid && (wready === 1'h1);
      b_go  = bready && (bvalid === 1'h1);
      r     = bresp;
      @(posedge aclk);
      if (aw_go)
        awvalid <= 1'h0;
      if (w_go)
        wvalid <= 1'h0;
    end
    bready <= 1'h0;
    @(posedge aclk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_go;
    logic r_go;
    r_go    = 1'h0;
    d       = 32'h0;
    r       = 2'h0;
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    while (!r_go)
    begin
      @(negedge aclk);
      ar_go = arvalid && (arready === 1'h1);
      r_go  = rready && (rvalid === 1'h1);
      d     = rdata;
      r     = rresp;
      @(posedge aclk);
      if (ar_go)
        arvalid <= 1'h0;
    end
    rready <= 1'h0;
    @(posedge aclk);
  endtask : rd_reg

  task automatic run_rows(input int lo, input int hi);
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = lo; i <= hi; i++)
    begin
      d = 32'h0;
      if (rows[i].wr)
        wr_reg(rows[i].a, rows[i].d, r);
      else
        rd_reg(rows[i].a, d, r);
      `CHK("resp", rows[i].rsp, r)
      `CHK("rdata", rows[i].rd, d)
      `CHK("irq", 1'h0, irq)
    end
  endtask : run_rows

  // Lines both owned and enabled drive; an open-drain line only ever pulls low
  task automatic chk_pad(input logic [31:0] dat, input logic [31:0] od);
    logic [31:0] drv;
    drv = line_owner & oe_st;
    `CHK("pad_oe", drv & ~(od & dat), pad.oe)
    `CHK("pad_out", dat & drv & ~od, pad.out & pad.oe)
  endtask : chk_pad

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    rows[0]  = '{1'h0, OFF_ODATA, 32'h0, RESP_OKAY, 32'h0};
    rows[1]  = '{1'h0, OFF_IRQ_MASK, 32'h0, RESP_OKAY, 32'h0};
    rows[2]  = '{1'h0, OFF_OD_STATE, 32'h0, RESP_OKAY, 32'h0};
    rows[3]  = '{1'h0, OFF_EDGE_FLAGS, 32'h0, RESP_OKAY, 32'h0};
    rows[4]  = '{1'h1, OFF_OUT_SET, 32'hA5A5_0F0F, RESP_OKAY, 32'h0};
    rows[5]  = '{1'h1, OFF_OUT_CLR, 32'h0000_000F, RESP_OKAY, 32'h0};
    rows[6]  = '{1'h0, OFF_ODATA, 32'h0, RESP_OKAY, 32'hA5A5_0F00};
    rows[7]  = '{1'h1, OFF_ODATA, 32'hFFFF_FFFF, RESP_SLVERR, 32'h0};
    rows[8]  = '{1'h0, OFF_ODATA, 32'h0, RESP_OKAY, 32'hA5A5_0F00};
    rows[9]  = '{1'h1, OFF_IRQ_EN_SET, 32'hFFFF_0000, RESP_OKAY, 32'h0};
    rows[10] = '{1'h1, OFF_IRQ_EN_CLR, 32'h0F00_0000, RESP_OKAY, 32'h0};
    rows[11] = '{1'h1, OFF_IRQ_EN_SET, 32'h0, RESP_OKAY, 32'h0};
    rows[12] = '{1'h0, OFF_IRQ_MASK, 32'h0, RESP_OKAY, 32'hF0FF_0000};
    rows[13] = '{1'h1, OFF_OD_SET, 32'h0000_FF00, RESP_OKAY, 32'h0};
    rows[14] = '{1'h1, OFF_OD_CLR, 32'h0000_0F00, RESP_OKAY, 32'h0};
    rows[15] = '{1'h0, OFF_OD_STATE, 32'h0, RESP_OKAY, 32'h0000_F000};
    rows[16] = '{1'h0, OFF_IRQ_EN_SET, 32'h0, RESP_OKAY, 32'h0};
    rows[17] = '{1'h0, 8'h60, 32'h0, RESP_SLVERR, 32'h0};
    rows[18] = '{1'h0, OFF_PIN_LEVEL, 32'h0, RESP_OKAY, 32'hFFFF_FFFF};
    rows[19] = '{1'h0, OFF_EDGE_FLAGS, 32'h0, RESP_OKAY, 32'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    run_rows(0, 19);
    line_owner <= 32'h0F0F_FFFF;
    oe_st      <= 32'hFFFF_F0FF;
    repeat (5) @(posedge aclk);
    chk_pad(32'hA5A5_0F00, 32'h0000_F000);
    `CHK("irq", 1'h1, irq)
    rd_reg(OFF_PIN_LEVEL, d, r);
    `CHK("pins", 32'hF5F5_0F00, d)
    rd_reg(OFF_EDGE_FLAGS, d, r);
    `CHK("flags", 32'h0A0A_F0FF, d)
    `CHK("irq", 1'h0, irq)
    rd_reg(OFF_EDGE_FLAGS, d, r);
    `CHK("flags", 32'h0, d)
    wr_reg(OFF_OUT_SET, 32'h0000_1000, r);
    repeat (4) @(posedge aclk);
    chk_pad(32'hA5A5_1F00, 32'h0000_F000);
    // Outside driver shares the released line and toggles an unowned input twice
    ext_en  <= 32'h8000_1000;
    ext_val <= 32'h0;
    repeat (5) @(posedge aclk);
    ext_val <= 32'h8000_0000;
    repeat (5) @(posedge aclk);
    `CHK("irq", 1'h1, irq)
    wr_reg(OFF_IRQ_EN_CLR, 32'h8000_0000, r);
    `CHK("irq", 1'h0, irq)
    rd_reg(OFF_IRQ_MASK, d, r);
    `CHK("mask", 32'h70FF_0000, d)
    rd_reg(OFF_PIN_LEVEL, d, r);
    `CHK("pins", 32'hF5F5_0F00, d)
    rd_reg(OFF_EDGE_FLAGS, d, r);
    `CHK("flags", 32'h8000_1000, d)
    ext_en <= 32'h0;
    wr_reg(OFF_OD_CLR, 32'h0000_1000, r);
    repeat (2) @(posedge aclk);
    chk_pad(32'hA5A5_1F00, 32'h0000_E000);
    // Only byte lane 1 of the clear word may take effect
    wstrb <= 4'h2;
    wr_reg(OFF_OUT_CLR, 32'hFFFF_FFFF, r);
    `CHK("resp_strb", RESP_OKAY, r)
    wstrb <= 4'hF;
    rd_reg(OFF_ODATA, d, r);
    `CHK("odata_strb", 32'hA5A5_0000, d)
    // Second reset in mid-run must bring output data, mask, open-drain and flag registers back to zero
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK("pad_oe_rst", 32'h0, pad.oe)
    `CHK("irq_rst", 1'h0, irq)
    line_owner <= 32'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    run_rows(0, 3);
    finish_test();
  end
endmodule : tb_parallel_io_status_irq_opendrain
